// file: src/sdcd_top.sv
// Command decoder of a low-power synchronous DRAM
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_cfg.svh"

// Functional notes
// - Commands and byte mask sampled on rising edge
// - Activate and precharge one or all banks
// - Column read/write, auto precharge closes row when burst_done ends the burst
// - Mode load when idle; refresh or self-refresh
// - No-op, burst stop, deselect decoded
// - Every command qualified by two clock-enable samples
// - Power-down entry and exit by clock enable
// - Clock enable drop during burst suspends it
// - Deep power-down entry from idle
// - Deep power-down exit on low-then-high enable
// - Bank state checked per addressed bank
// - Extended operating mode must be zero; a nonzero value is still loaded and sets ext_mode_reserved
module sdcd_top #(
  parameter int NUM_BANKS = `SDCD_NUM_BANKS,
  parameter int BA_W = `SDCD_BA_W,
  parameter int ADDR_W = `SDCD_ADDR_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic dqm,
  input wire logic [BA_W-1:0] bank_address,
  input wire logic auto_precharge_bit,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic burst_done,
  output logic [NUM_BANKS-1:0] bank_active,
  output logic burst_active,
  output logic burst_write,
  output logic burst_frozen,
  output logic data_enable,
  output sdcd_pkg::sdcd_pwr_e pwr_state,
  output sdcd_pkg::sdcd_cmd_e last_cmd,
  output logic refresh_pulse,
  output logic [ADDR_W-1:0] mode_reg,
  output logic [ADDR_W-1:0] ext_mode_reg,
  output logic ext_mode_reserved,
  output logic init_required
);

  // Bank tracker strobes
  sdcd_bank_if #(.NUM_BANKS(NUM_BANKS)) bif ();

  // Registered state
  logic cke_prev_ff;                      // Clock enable of previous edge
  sdcd_pkg::sdcd_pwr_e pwr_ff;            // Power state
  sdcd_pkg::sdcd_cmd_e cmd_ff;            // Last executed command
  logic burst_ff;                         // Burst running
  logic burst_wr_ff;                      // Burst is a write
  logic burst_ap_ff;                      // Burst closes its row at end
  logic [BA_W-1:0] burst_bank_ff;         // Bank of running burst
  logic refresh_ff;                       // Refresh strobe
  logic data_en_ff;                       // Data mask result
  logic [ADDR_W-1:0] mode_ff;             // Mode register
  logic [ADDR_W-1:0] ext_mode_ff;         // Extended mode register
  logic ext_rsv_ff;                       // Reserved operating mode seen
  logic init_req_ff;                      // Reinit needed

  // Next values
  sdcd_pkg::sdcd_pwr_e nxt_pwr_ff;
  sdcd_pkg::sdcd_cmd_e nxt_cmd_ff;
  logic nxt_burst_ff;
  logic nxt_burst_wr_ff;
  logic nxt_burst_ap_ff;
  logic [BA_W-1:0] nxt_burst_bank_ff;
  logic nxt_refresh_ff;
  logic nxt_data_en_ff;
  logic [ADDR_W-1:0] nxt_mode_ff;
  logic [ADDR_W-1:0] nxt_ext_mode_ff;
  logic nxt_ext_rsv_ff;
  logic nxt_init_req_ff;
  logic [NUM_BANKS-1:0] open_mask;
  logic [NUM_BANKS-1:0] close_mask;

  // Decode helpers
  logic all_idle;   // No bank open
  logic sel_active; // Addressed bank open
  logic cke_valid;  // Previous enable high, commands accepted
  logic cke_fall;   // High then low
  logic cke_rise;   // Low then high
  logic [NUM_BANKS-1:0] sel_mask; // One-hot addressed bank

  assign all_idle = ~|bif.active;
  assign sel_mask = NUM_BANKS'(1) << bank_address;
  assign sel_active = |(bif.active & sel_mask);
  assign cke_valid = cke_prev_ff;
  assign cke_fall = cke_prev_ff & ~cke;
  assign cke_rise = ~cke_prev_ff & cke;

  // Command and power state decode
  always_comb begin
    nxt_pwr_ff = pwr_ff;
    nxt_cmd_ff = sdcd_pkg::CMD_NONE;
    nxt_burst_ff = burst_ff;
    nxt_burst_wr_ff = burst_wr_ff;
    nxt_burst_ap_ff = burst_ap_ff;
    nxt_burst_bank_ff = burst_bank_ff;
    nxt_refresh_ff = 1'b0;
    nxt_mode_ff = mode_ff;
    nxt_ext_mode_ff = ext_mode_ff;
    nxt_ext_rsv_ff = ext_rsv_ff;
    nxt_init_req_ff = init_req_ff;
    open_mask = '0;
    close_mask = '0;
    // Burst end from the outside counter; auto precharge closes its row
    if (burst_ff && burst_done && pwr_ff == sdcd_pkg::PWR_NORMAL) begin
      nxt_burst_ff = 1'b0;
      if (burst_ap_ff) begin
        close_mask = NUM_BANKS'(1) << burst_bank_ff;
      end
    end
    case (pwr_ff)
      sdcd_pkg::PWR_NORMAL: begin
        if (cke_fall) begin
          // Low-power entries
          if (burst_ff) begin
            nxt_pwr_ff = sdcd_pkg::PWR_SUSPEND;
            nxt_cmd_ff = sdcd_pkg::CMD_PWR_ENTRY;
          end else if (!cs_n && !ras_n && !cas_n && we_n && all_idle) begin
            nxt_pwr_ff = sdcd_pkg::PWR_SREF;
            nxt_cmd_ff = sdcd_pkg::CMD_PWR_ENTRY;
          end else if (!cs_n && ras_n && cas_n && !we_n && all_idle) begin
            nxt_pwr_ff = sdcd_pkg::PWR_DEEP;
            nxt_cmd_ff = sdcd_pkg::CMD_PWR_ENTRY;
          end else if (cs_n || (ras_n && cas_n && we_n)) begin
            nxt_pwr_ff = sdcd_pkg::PWR_PDOWN;
            nxt_cmd_ff = sdcd_pkg::CMD_PWR_ENTRY;
          end
        end else if (cke_valid && !cs_n) begin
          // Chip selected; deselect falls through as nothing
          case ({ras_n, cas_n, we_n})
            3'b011: begin
              // Activate only an idle bank
              if (!sel_active) begin
                open_mask = sel_mask;
                nxt_cmd_ff = sdcd_pkg::CMD_ACTIVATE;
              end
            end
            3'b010: begin
              // Precharge one or all, any state
              if (auto_precharge_bit) begin
                close_mask = '1;
                nxt_cmd_ff = sdcd_pkg::CMD_PRE_ALL;
              end else begin
                close_mask = close_mask | sel_mask;
                nxt_cmd_ff = sdcd_pkg::CMD_PRE_BANK;
              end
              if (burst_ff && (auto_precharge_bit || burst_bank_ff == bank_address)) begin
                nxt_burst_ff = 1'b0;
              end
            end
            3'b100, 3'b101: begin
              // Column access to an open bank; new access replaces old burst
              if (sel_active) begin
                nxt_burst_ff = 1'b1;
                nxt_burst_wr_ff = ~we_n;
                nxt_burst_ap_ff = auto_precharge_bit;
                nxt_burst_bank_ff = bank_address;
                nxt_cmd_ff = we_n ? sdcd_pkg::CMD_READ : sdcd_pkg::CMD_WRITE;
              end else begin
                nxt_cmd_ff = sdcd_pkg::CMD_NONE;
              end
            end
            3'b000: begin
              // Mode load only when idle with no burst
              if (all_idle && !burst_ff) begin
                nxt_cmd_ff = sdcd_pkg::CMD_MODE_SET;
                nxt_init_req_ff = 1'b0;
                if (bank_address == `SDCD_MRS_SEL_EXT) begin
                  nxt_ext_mode_ff = addr;
                  nxt_ext_rsv_ff = addr[`SDCD_EXT_OPMODE_MSB:`SDCD_EXT_OPMODE_LSB]
                    != `SDCD_EXT_OPMODE_NORMAL;
                end else if (bank_address == `SDCD_MRS_SEL_BASE) begin
                  nxt_mode_ff = addr;
                end
              end
            end
            3'b001: begin
              // Auto refresh with enable held high
              if (all_idle && !burst_ff) begin
                nxt_refresh_ff = 1'b1;
                nxt_cmd_ff = sdcd_pkg::CMD_REFRESH;
              end
            end
            3'b110: begin
              // Burst stop
              if (burst_ff) begin
                nxt_burst_ff = 1'b0;
                nxt_cmd_ff = sdcd_pkg::CMD_BURST_STOP;
              end
            end
            default: begin
              // No-operation
              nxt_cmd_ff = sdcd_pkg::CMD_NONE;
            end
          endcase
        end
      end
      sdcd_pkg::PWR_PDOWN, sdcd_pkg::PWR_SREF: begin
        // Exit needs deselect or both strobes high
        if (cke_rise && (cs_n || (ras_n && cas_n))) begin
          nxt_pwr_ff = sdcd_pkg::PWR_NORMAL;
          nxt_cmd_ff = sdcd_pkg::CMD_PWR_EXIT;
        end
      end
      sdcd_pkg::PWR_SUSPEND: begin
        // Burst frozen; inputs ignored
        if (cke_rise) begin
          nxt_pwr_ff = sdcd_pkg::PWR_NORMAL;
          nxt_cmd_ff = sdcd_pkg::CMD_PWR_EXIT;
        end
      end
      sdcd_pkg::PWR_DEEP: begin
        // Configuration lost; controller must reinitialise
        if (cke_rise) begin
          nxt_pwr_ff = sdcd_pkg::PWR_NORMAL;
          nxt_cmd_ff = sdcd_pkg::CMD_PWR_EXIT;
          nxt_mode_ff = `SDCD_MODE_RST;
          nxt_ext_mode_ff = `SDCD_EXT_MODE_RST;
          nxt_ext_rsv_ff = 1'b0;
          nxt_init_req_ff = 1'b1;
        end
      end
      default: begin
        nxt_pwr_ff = sdcd_pkg::PWR_NORMAL;
      end
    endcase
  end

  // Byte mask gate while a bank is open
  always_comb begin
    nxt_data_en_ff = (|bif.active) && !dqm && cke_valid;
  end

  assign bif.open_mask = open_mask;
  assign bif.close_mask = close_mask;

  // State registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cke_prev_ff <= `SDCD_CKE_RST;
      pwr_ff <= sdcd_pkg::PWR_NORMAL;
      cmd_ff <= sdcd_pkg::CMD_NONE;
      burst_ff <= 1'b0;
      burst_wr_ff <= 1'b0;
      burst_ap_ff <= 1'b0;
      burst_bank_ff <= '0;
      refresh_ff <= 1'b0;
      data_en_ff <= 1'b0;
      mode_ff <= `SDCD_MODE_RST;
      ext_mode_ff <= `SDCD_EXT_MODE_RST;
      ext_rsv_ff <= 1'b0;
      init_req_ff <= 1'b0;
    end else begin
      cke_prev_ff <= cke;
      pwr_ff <= nxt_pwr_ff;
      cmd_ff <= nxt_cmd_ff;
      burst_ff <= nxt_burst_ff;
      burst_wr_ff <= nxt_burst_wr_ff;
      burst_ap_ff <= nxt_burst_ap_ff;
      burst_bank_ff <= nxt_burst_bank_ff;
      refresh_ff <= nxt_refresh_ff;
      data_en_ff <= nxt_data_en_ff;
      mode_ff <= nxt_mode_ff;
      ext_mode_ff <= nxt_ext_mode_ff;
      ext_rsv_ff <= nxt_ext_rsv_ff;
      init_req_ff <= nxt_init_req_ff;
    end
  end

  // One tracker per bank
  for (genvar gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
    sdcd_bank #(.INDEX(gi)) u_bank (
      .clock(clock),
      .arst_n(arst_n),
      .bif(bif)
    );
  end

  // Outputs
  assign bank_active = bif.active;
  assign burst_active = burst_ff;
  assign burst_write = burst_wr_ff;
  assign burst_frozen = (pwr_ff == sdcd_pkg::PWR_SUSPEND);
  assign data_enable = data_en_ff;
  assign pwr_state = pwr_ff;
  assign last_cmd = cmd_ff;
  assign refresh_pulse = refresh_ff;
  assign mode_reg = mode_ff;
  assign ext_mode_reg = ext_mode_ff;
  assign ext_mode_reserved = ext_rsv_ff;
  assign init_required = init_req_ff;

endmodule
`default_nettype wire

// file: inc/sdcd_cfg.svh
// Constants of the command decoder: field positions, codes and reset values
`ifndef SDCD_CFG_SVH
`define SDCD_CFG_SVH

// Number of banks and bank address width
`define SDCD_NUM_BANKS 4
`define SDCD_BA_W 2
// Width of the mode register address bus
`define SDCD_ADDR_W 13

// Bank address values that select the target of a mode register load
`define SDCD_MRS_SEL_BASE 2'h0
`define SDCD_MRS_SEL_EXT 2'h2

// Operating-mode field of the extended mode register
`define SDCD_EXT_OPMODE_MSB 12
`define SDCD_EXT_OPMODE_LSB 5
`define SDCD_EXT_OPMODE_NORMAL 8'h00

// Reset values
`define SDCD_MODE_RST 13'h0000
`define SDCD_EXT_MODE_RST 13'h0000
`define SDCD_CKE_RST 1'b1

`endif

// file: inc/sdcd_pkg.sv
// Types shared by the command decoder, its monitor and its bench
`default_nettype none
package sdcd_pkg;

  // Power state, one-hot
  typedef enum logic [4:0] {
    PWR_NORMAL  = 5'b0_0001,
    PWR_PDOWN   = 5'b0_0010,
    PWR_SREF    = 5'b0_0100,
    PWR_SUSPEND = 5'b0_1000,
    PWR_DEEP    = 5'b1_0000
  } sdcd_pwr_e;

  // Command that took effect on the last edge
  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_ACTIVATE = 4'h1,
    CMD_PRE_BANK = 4'h2,
    CMD_PRE_ALL  = 4'h3,
    CMD_READ     = 4'h4,
    CMD_WRITE    = 4'h5,
    CMD_MODE_SET = 4'h6,
    CMD_REFRESH  = 4'h7,
    CMD_BURST_STOP = 4'h8,
    CMD_PWR_ENTRY = 4'h9,
    CMD_PWR_EXIT = 4'ha
  } sdcd_cmd_e;

endpackage
`default_nettype wire

// file: inc/sdcd_bank_if.sv
// Open and close strobes from the decoder to the bank trackers
`timescale 1ns/1ps
`default_nettype none
interface sdcd_bank_if #(
  parameter int NUM_BANKS = 4
);
  logic [NUM_BANKS-1:0] open_mask;  // Open the row of a bank
  logic [NUM_BANKS-1:0] close_mask; // Precharge a bank
  logic [NUM_BANKS-1:0] active;     // Bank holds an open row

  modport ctrl (output open_mask, output close_mask, input active);
  modport bank (input open_mask, input close_mask, output active);
endinterface
`default_nettype wire

// file: src/sdcd_bank.sv
// Idle/active tracker of one bank
`timescale 1ns/1ps
`default_nettype none
module sdcd_bank #(
  parameter int INDEX = 0
) (
  input wire logic clock,
  input wire logic arst_n,
  sdcd_bank_if.bank bif
);

  logic active_ff;     // Row open
  logic nxt_active_ff; // Next row state

  // Close wins over open; the decoder never asks both at once
  always_comb begin
    nxt_active_ff = active_ff;
    if (bif.close_mask[INDEX]) begin
      nxt_active_ff = 1'b0;
    end else if (bif.open_mask[INDEX]) begin
      nxt_active_ff = 1'b1;
    end
  end

  // Bank state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active_ff;
    end
  end

  assign bif.active[INDEX] = active_ff;

endmodule
`default_nettype wire

// file: verif/sdcd_monitor.sv
// Concurrent checks on the command decoder ports
`timescale 1ns/1ps
`default_nettype none
module sdcd_monitor #(
  parameter int NUM_BANKS = 4,
  parameter int BA_W = 2,
  parameter int ADDR_W = 13
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] bank_address,
  input wire logic auto_precharge_bit,
  input wire logic burst_done,
  input wire logic [NUM_BANKS-1:0] bank_active,
  input wire logic burst_active,
  input wire logic burst_write,
  input wire sdcd_pkg::sdcd_pwr_e pwr_state,
  input wire sdcd_pkg::sdcd_cmd_e last_cmd,
  input wire logic refresh_pulse,
  input wire logic [ADDR_W-1:0] mode_reg,
  input wire logic init_required
);
  logic cke_ff; // Enable one edge back
  logic nxt_cke;
  logic norm; // Command would be taken
  // Next enable sample
  always_comb begin
    nxt_cke = cke;
  end
  // Enable history, high out of reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cke_ff <= 1'b1;
    end else begin
      cke_ff <= nxt_cke;
    end
  end
  assign norm = pwr_state == sdcd_pkg::PWR_NORMAL && cke_ff && cke && !cs_n;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Enable falls in normal state
  sequence s_fall;
    pwr_state == sdcd_pkg::PWR_NORMAL && cke_ff && !cke;
  endsequence
  property p_act;
    norm && !ras_n && cas_n && we_n && !bank_active[bank_address]
    |=> bank_active[$past(bank_address)] && last_cmd == sdcd_pkg::CMD_ACTIVATE;
  endproperty
  a_act: assert property (p_act) else $error("activate lost");
  property p_pall;
    norm && !ras_n && cas_n && !we_n && auto_precharge_bit |=> bank_active == '0;
  endproperty
  a_pall: assert property (p_pall) else $error("banks left open");
  property p_col;
    norm && ras_n && !cas_n && bank_active[bank_address]
    |=> burst_active && burst_write == $past(!we_n);
  endproperty
  a_col: assert property (p_col) else $error("column access wrong");
  property p_ill;
    norm && ras_n && !cas_n && !bank_active[bank_address]
    |=> last_cmd == sdcd_pkg::CMD_NONE && $stable(bank_active);
  endproperty
  a_ill: assert property (p_ill) else $error("idle bank access taken");
  property p_ref;
    norm && !ras_n && !cas_n && we_n && bank_active == '0 && !burst_active |=> refresh_pulse;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh lost");
  property p_pdn;
    s_fall ##0 (cs_n || (ras_n && cas_n && we_n)) && !burst_active
    |=> pwr_state == sdcd_pkg::PWR_PDOWN;
  endproperty
  a_pdn: assert property (p_pdn) else $error("no power-down");
  property p_sus;
    s_fall ##0 burst_active && !burst_done |=> pwr_state == sdcd_pkg::PWR_SUSPEND;
  endproperty
  a_sus: assert property (p_sus) else $error("no suspend");
  property p_dpd;
    s_fall ##0 !cs_n && ras_n && cas_n && !we_n && bank_active == '0 && !burst_active
    |=> pwr_state == sdcd_pkg::PWR_DEEP;
  endproperty
  a_dpd: assert property (p_dpd) else $error("no deep entry");
  property p_dpx;
    pwr_state == sdcd_pkg::PWR_DEEP && !cke_ff && cke
    |=> pwr_state == sdcd_pkg::PWR_NORMAL && init_required && mode_reg == '0;
  endproperty
  a_dpx: assert property (p_dpx) else $error("bad deep exit");
  property p_hold;
    pwr_state == sdcd_pkg::PWR_SREF && !cke |=> pwr_state == sdcd_pkg::PWR_SREF;
  endproperty
  a_hold: assert property (p_hold) else $error("left self-refresh");
endmodule
bind sdcd_top sdcd_monitor #(.NUM_BANKS(NUM_BANKS), .BA_W(BA_W), .ADDR_W(ADDR_W)) mon_i (
  .clock(clock), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .bank_address(bank_address), .auto_precharge_bit(auto_precharge_bit),
  .burst_done(burst_done), .bank_active(bank_active), .burst_active(burst_active),
  .burst_write(burst_write), .pwr_state(pwr_state), .last_cmd(last_cmd),
  .refresh_pulse(refresh_pulse), .mode_reg(mode_reg), .init_required(init_required));
`default_nettype wire

// file: verif/sdcd_ctrl_model.sv
// Memory controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
  input wire logic clock,
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [1:0] bank_address,
  output var logic auto_precharge_bit
);
  // Deselected with enable high at time zero
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_address = 2'h0;
    auto_precharge_bit = 1'b0;
  end
  // One command per edge, launched just after it
  task automatic issue(input logic [3:0] c, input logic k, input logic [1:0] b,
                       input logic a);
    @(posedge clock);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    cke = k;
    bank_address = b;
    auto_precharge_bit = a;
  endtask
endmodule
`default_nettype wire

// file: verif/sdcd_top_bench.sv
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`default_nettype none
module sdcd_top_bench;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] MRS = 4'h0, REF = 4'h1, BST = 4'h6, DES = 4'hf;
  localparam sdcd_pkg::sdcd_cmd_e N = sdcd_pkg::CMD_NONE;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, ap;
  logic dqm = 1'b0;
  logic bd = 1'b0; // Burst end pulse
  logic [1:0] ba;
  logic [12:0] addr = 13'h0000;
  logic [12:0] m0, m2; // Values loaded
  logic [3:0] bank_active;
  logic burst_active, refresh_pulse, ext_mode_reserved, init_required;
  logic burst_frozen, data_enable;
  logic dm; // Byte mask that stood with a noted command
  logic [12:0] mode_reg, ext_mode_reg;
  sdcd_pkg::sdcd_pwr_e pwr_state;
  sdcd_pkg::sdcd_cmd_e last_cmd;
  sdcd_pkg::sdcd_cmd_e exp_q[$]; // Expected taken commands
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'hc2e5;
  always #2.5 clock = ~clock;
  sdcd_ctrl_model sdcd_ctrl_model_i (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_address(ba), .auto_precharge_bit(ap));
  sdcd_top sdcd_top_i (.clock(clock), .arst_n(arst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dqm(dqm), .bank_address(ba),
    .auto_precharge_bit(ap), .addr(addr), .burst_done(bd), .bank_active(bank_active),
    .burst_active(burst_active), .burst_write(), .burst_frozen(burst_frozen),
    .data_enable(data_enable),
    .pwr_state(pwr_state), .last_cmd(last_cmd), .refresh_pulse(refresh_pulse),
    .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
    .ext_mode_reserved(ext_mode_reserved), .init_required(init_required));
  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Command compare against oldest note
  task automatic chk_cmd(input sdcd_pkg::sdcd_cmd_e got);
    sdcd_pkg::sdcd_cmd_e e;
    e = exp_q.size() != 0 ? exp_q.pop_front() : N;
    chk(16'(got), 16'(e));
  endtask
  // Issue a command and note its expected result
  task automatic go(input logic [3:0] c, input logic k, input logic [1:0] b, input logic a,
                    input sdcd_pkg::sdcd_cmd_e e);
    sdcd_ctrl_model_i.issue(c, k, b, a);
    addr = 13'($random(seed));
    dqm = 1'($random(seed));
    if (e != N) begin
      exp_q.push_back(e);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    if (exp_q.size() != 0) begin
      miscompares++;
    end
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watches taken commands
  always @(negedge clock) begin
    if (arst_n && last_cmd !== N && last_cmd < sdcd_pkg::CMD_PWR_ENTRY) begin
      chk_cmd(last_cmd);
    end
  end
  // Hang guard
  initial begin
    #50000;
    miscompares++;
    results();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    #1;
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(MRS, 1, 2'(i), 0, sdcd_pkg::CMD_MODE_SET);
      // Address drawn in go stands with this load
      if (i == 0) m0 = addr;
      if (i == 2) m2 = addr;
    end
    go(RD, 1, 1, 0, N);
    chk(16'(mode_reg), 16'(m0));
    chk(16'(ext_mode_reg), 16'(m2));
    chk(16'(ext_mode_reserved), 16'(|m2[12:5]));
    for (int i = 0; i < 4; i++) begin
      go(ACT, 1, 2'(i), 0, sdcd_pkg::CMD_ACTIVATE);
    end
    go(ACT, 1, 0, 0, N);
    go(REF, 1, 0, 0, N);
    go(PRE, 1, 2, 0, sdcd_pkg::CMD_PRE_BANK);
    dm = dqm;
    go(RD, 1, 1, 1, sdcd_pkg::CMD_READ);
    chk(16'(bank_active), 16'h000b);
    chk(16'(data_enable), 16'(!dm));
    go(NOP, 1, 0, 0, N);
    bd = 1'b1;
    go(NOP, 1, 0, 0, N);
    bd = 1'b0;
    chk(16'(bank_active), 16'h0009);
    go(WR, 1, 0, 0, sdcd_pkg::CMD_WRITE);
    go(BST, 1, 0, 0, sdcd_pkg::CMD_BURST_STOP);
    go({1'b1, 3'($random(seed))}, 1, 0, 0, N);
    chk(16'(burst_active), 16'h0000);
    go(WR, 1, 3, 0, sdcd_pkg::CMD_WRITE);
    go(NOP, 0, 0, 0, N);
    go(ACT, 0, 2, 0, N);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_SUSPEND));
    chk(16'(burst_frozen), 16'h0001);
    go(ACT, 1, 2, 0, N);
    go(BST, 1, 0, 0, sdcd_pkg::CMD_BURST_STOP);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_NORMAL));
    chk(16'(burst_frozen), 16'h0000);
    chk(16'(bank_active), 16'h0009);
    go(DES, 0, 0, 0, N);
    go(NOP, 0, 0, 0, N);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_PDOWN));
    go(NOP, 1, 0, 0, N);
    go(PRE, 1, 0, 1, sdcd_pkg::CMD_PRE_ALL);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_NORMAL));
    go(REF, 1, 0, 0, sdcd_pkg::CMD_REFRESH);
    go(NOP, 1, 0, 0, N);
    chk(16'(refresh_pulse), 16'h0001);
    chk(16'(bank_active), 16'h0000);
    chk(16'(data_enable), 16'h0000);
    go(REF, 0, 0, 0, N);
    go(ACT, 0, 1, 0, N);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_SREF));
    go(DES, 1, 0, 0, N);
    go(NOP, 1, 0, 0, N);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_NORMAL));
    chk(16'(bank_active), 16'h0000);
    go(BST, 0, 0, 0, N);
    go(DES, 0, 0, 0, N);
    chk(16'(pwr_state), 16'(sdcd_pkg::PWR_DEEP));
    go(MRS, 1, 0, 0, N);
    go(NOP, 1, 0, 0, N);
    chk(16'(init_required), 16'h0001);
    chk(16'(mode_reg), 16'h0000);
    go(MRS, 1, 0, 0, sdcd_pkg::CMD_MODE_SET);
    go(NOP, 1, 0, 0, N);
    chk(16'(init_required), 16'h0000);
    go(NOP, 1, 0, 0, N);
    results();
  end
endmodule
`default_nettype wire
